// *** sacp_pkg.sv ***
package sacp_pkg;

    // ************************************************************
    // Clock rates and timing
    // ************************************************************
    localparam longint MCLK_PS       = 4000;
    localparam longint LINK_CLK_PS   = 15000;
    localparam longint SCLK_HZ       = 1_280_000;
    // Half period of the shift clock in link clock cycles, rounded down
    localparam int     SCLK_HALF_CYC = int'((64'd1_000_000_000_000 / (2 * SCLK_HZ)) / LINK_CLK_PS);
    localparam longint POR_WAIT_MS   = 100;
    localparam int     POR_WAIT_CYC  = int'((POR_WAIT_MS * 64'd1_000_000_000) / MCLK_PS);
    localparam longint LOWBAT_NS     = 44_000;
    localparam int     LOWBAT_CYC    = int'((LOWBAT_NS * 64'd1000) / MCLK_PS);

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int FRAME_BITS    = 32;
    localparam int HALF_FRAME    = 16;
    localparam int TX_BITS       = 24;
    localparam int TX_AUDIO_BITS = 16;
    localparam int RX_AUDIO_BITS = 20;
    localparam int CTL_BITS      = 12;
    localparam int SPI_IDLE_CYC  = 8;
    localparam int SPI_PULSE_CYC = 4;

    // Control word fields and the crossing word that carries them
    localparam int CTL_RW_BIT    = 11;
    localparam int CTL_ADDR_MSB  = 10;
    localparam int CTL_ADDR_LSB  = 8;
    localparam int CTL_DATA_MSB  = 7;
    localparam int RXW_BITS      = 33;
    localparam int RXW_PROTO_BIT = 32;
    localparam int RXW_AUDIO_LSB = 12;

    // ************************************************************
    // Control registers
    // ************************************************************
    localparam int         NUM_REGS  = 5;
    localparam logic [2:0] REG_FIRST = 3'h1;
    localparam logic [2:0] REG_LAST  = 3'h5;
    // Index 0 is address 1: gain, filter/shift, power down, fast rate, slow rate
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET     = {8'h42, 8'hF7, 8'h00, 8'h00, 8'h46};
    localparam logic [NUM_REGS-1:0][7:0] REG_USED_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    typedef enum logic {
        PROTO_DSP = 1'b0,
        PROTO_SPI = 1'b1
    } sacp_proto_t;

    typedef enum logic [2:0] {
        LS_OFF   = 3'b001,
        LS_IDLE  = 3'b010,
        LS_FRAME = 3'b100
    } sacp_lstate_t;

endpackage : sacp_pkg

// *** sacp_sync.sv ***
`timescale 1ns/10ps
module sacp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import sacp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sacp_sync_st_t;

    sacp_sync_st_t s_q;
    sacp_sync_st_t s_d;

    // Two stages; the first stage feeds only the second
    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.held = s_q.meta;
    end

    // No reset: these carry data only, settled within two edges
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign sync_out = s_q.held;

endmodule : sacp_sync

// *** sacp_port.sv ***
`timescale 1ns/10ps
module sacp_port
    import sacp_pkg::*;
#(
    parameter int POR_WAIT = sacp_pkg::POR_WAIT_CYC,
    parameter int LOWBAT   = sacp_pkg::LOWBAT_CYC
) (
    input  wire logic                                    mclk,
    input  wire logic                                    rst,
    input  wire logic                                    link_clk,
    input  wire logic                                    por_rst_n,
    input  wire logic                                    supply_low,
    input  wire logic                                    protocol_select_pin,
    input  wire logic                                    serial_in_line,
    input  wire logic                                    dac_word_mode,
    input  wire logic [sacp_pkg::TX_AUDIO_BITS-1:0]      adc_sample,
    input  wire logic                                    adc_valid,
    output logic                                         sclk,
    output logic                                         frame_sync,
    output logic                                         serial_out_line,
    output logic [sacp_pkg::RX_AUDIO_BITS-1:0]           dac_sample,
    output logic                                         dac_valid,
    output logic [sacp_pkg::NUM_REGS-1:0][7:0]           ctrl_regs,
    output logic                                         port_active,
    output logic                                         dac_gated
);
    import sacp_pkg::*;

    // ************************************************************
    // State of both clock domains
    // ************************************************************
    typedef struct packed {
        sacp_lstate_t          st;
        logic [4:0]            div;
        logic                  ph;
        logic                  sclk;
        logic                  frame;
        logic                  sdo;
        logic [4:0]            bit_idx;
        logic [3:0]            idle_cnt;
        sacp_proto_t           proto;
        logic [FRAME_BITS-1:0] tx_sh;
        logic [FRAME_BITS-1:0] rx_sh;
        logic [RXW_BITS-1:0]   rx_word;
        logic                  rx_tog;
        logic [TX_BITS-1:0]    tx_buf;
        logic                  tx_seen;
    } sacp_lst_t;

    typedef struct packed {
        logic [31:0]                 por_cnt;
        logic                        port_en;
        logic [31:0]                 low_cnt;
        logic                        dac_gate;
        logic                        rx_seen;
        logic [NUM_REGS-1:0][7:0]    regs;
        logic [2:0]                  rb_addr;
        logic                        pend_valid;
        logic                        pend_rw;
        logic [2:0]                  pend_addr;
        logic [RX_AUDIO_BITS-1:0]    dac;
        logic                        dac_valid;
        logic [TX_AUDIO_BITS-1:0]    adc_hold;
        logic [TX_BITS-1:0]          tx_hold;
        logic                        tx_tog;
    } sacp_mst_t;

    localparam logic [4:0] DIV_LAST = 5'(SCLK_HALF_CYC - 1);
    localparam logic [4:0] BIT_LAST = 5'(FRAME_BITS - 1);

    sacp_lst_t l_q;
    sacp_lst_t l_d;
    sacp_mst_t m_q;
    sacp_mst_t m_d;

    logic link_rst;
    logic en_l;
    logic proto_l;
    logic sin_l;
    logic tx_tog_l;
    logic por_ok_m;
    logic low_m;
    logic rx_tog_m;
    logic tick;
    logic fall;
    logic rise;
    logic start;

    // ************************************************************
    // Crossings into each domain
    // ************************************************************
    // Power-on reset, supply monitor and frame toggle reach mclk
    sacp_sync #(.WIDTH(3)) u_sync_m (
        .clk      (mclk),
        .async_in ({por_rst_n, supply_low, l_q.rx_tog}),
        .sync_out ({por_ok_m, low_m, rx_tog_m})
    );

    // Reset, enable, pins and the reply toggle reach the link side
    sacp_sync #(.WIDTH(5)) u_sync_l (
        .clk      (link_clk),
        .async_in ({rst, m_q.port_en, protocol_select_pin, serial_in_line, m_q.tx_tog}),
        .sync_out ({link_rst, en_l, proto_l, sin_l, tx_tog_l})
    );

    // ************************************************************
    // Link side: shift clock, frame strobe, shifters
    // ************************************************************
    // Shift clock phase events, one link cycle wide
    assign tick = (l_q.div == DIV_LAST);
    assign fall = tick & l_q.ph;
    assign rise = tick & ~l_q.ph;

    always_comb begin
        l_d   = l_q;
        start = 1'b0;
        // Divider runs free so every frame starts on a clean half period
        l_d.div = tick ? 5'h0 : l_q.div + 5'h1;
        l_d.ph  = tick ? ~l_q.ph : l_q.ph;
        // Reply word is stable long before its toggle arrives
        if (tx_tog_l != l_q.tx_seen) begin
            l_d.tx_buf  = m_q.tx_hold;
            l_d.tx_seen = tx_tog_l;
        end
        // Sample the input on the rising edge, shifting in MSB first
        if (rise && (l_q.st == LS_FRAME)) begin
            l_d.rx_sh = {l_q.rx_sh[FRAME_BITS-2:0], sin_l};
        end
        if (fall) begin
            unique case (l_q.st)
                LS_OFF: begin
                    if (en_l) begin
                        if (proto_l == PROTO_SPI) begin
                            l_d.st       = LS_IDLE;
                            l_d.idle_cnt = 4'h0;
                            l_d.frame    = 1'b1;
                        end else begin
                            start = 1'b1;
                        end
                    end
                end
                LS_IDLE: begin
                    // Slave reset pulse, then strobe low before data
                    l_d.idle_cnt = l_q.idle_cnt + 4'h1;
                    if (l_q.idle_cnt == 4'(SPI_PULSE_CYC - 1)) begin
                        l_d.frame = 1'b0;
                    end
                    if (l_q.idle_cnt == 4'(SPI_IDLE_CYC - 1)) begin
                        start = 1'b1;
                    end
                end
                LS_FRAME: begin
                    if (l_q.bit_idx == BIT_LAST) begin
                        // Hand the whole frame to mclk with one toggle
                        l_d.rx_word = {l_q.proto, l_q.rx_sh};
                        l_d.rx_tog  = ~l_q.rx_tog;
                        if (!en_l) begin
                            l_d.st    = LS_OFF;
                            l_d.frame = 1'b0;
                            l_d.sdo   = 1'b0;
                        end else if ((proto_l == PROTO_SPI) && (l_q.proto == PROTO_DSP)) begin
                            l_d.st       = LS_IDLE;
                            l_d.idle_cnt = 4'h0;
                            l_d.frame    = 1'b1;
                            l_d.sdo      = 1'b0;
                        end else begin
                            start = 1'b1;
                        end
                    end else begin
                        // Launch the next bit on the falling edge
                        l_d.bit_idx = l_q.bit_idx + 5'h1;
                        l_d.sdo     = l_q.tx_sh[FRAME_BITS-2];
                        l_d.tx_sh   = {l_q.tx_sh[FRAME_BITS-2:0], 1'b0};
                        l_d.frame   = (l_q.proto == PROTO_DSP) &&
                                      (l_d.bit_idx < 5'(HALF_FRAME));
                    end
                end
                default: begin
                    l_d.st = LS_OFF;
                end
            endcase
        end
        // Frame start: protocol latched per frame, 24 bits then zeros
        if (start) begin
            l_d.st      = LS_FRAME;
            l_d.bit_idx = 5'h0;
            l_d.proto   = sacp_proto_t'(proto_l);
            l_d.tx_sh   = {l_q.tx_buf, 8'h00};
            l_d.sdo     = l_q.tx_buf[TX_BITS-1];
            l_d.frame   = (proto_l == PROTO_DSP);
        end
        // Clock pin held low while the port is off
        l_d.sclk = l_d.ph & (l_d.st != LS_OFF);
        if (link_rst) begin
            l_d    = '0;
            l_d.st = LS_OFF;
        end
    end

    always_ff @(posedge link_clk) begin
        l_q <= l_d;
    end

    // ************************************************************
    // Register file access helpers
    // ************************************************************
    function automatic logic [7:0] sacp_read(input logic [NUM_REGS-1:0][7:0] regs,
                                             input logic [2:0]               a);
        logic [7:0] v;
        v = 8'h00;
        // Reserved and zero addresses read as zero
        if ((a >= REG_FIRST) && (a <= REG_LAST)) begin
            v = regs[a - 3'h1] & REG_USED_MASK[a - 3'h1];
        end
        return v;
    endfunction : sacp_read

    // ************************************************************
    // mclk side: power-up, low battery, control decode
    // ************************************************************
    logic                 ev;
    sacp_proto_t          ev_proto;
    logic [CTL_BITS-1:0]  ev_ctl;
    logic [2:0]           ev_addr;
    logic                 ev_rw;
    logic [7:0]           ev_data;
    logic [2:0]           wr_addr;
    logic                 wr_en;

    // The crossing word is stable while its toggle is fresh
    assign ev       = (rx_tog_m != m_q.rx_seen);
    assign ev_proto = sacp_proto_t'(l_q.rx_word[RXW_PROTO_BIT]);
    assign ev_ctl   = l_q.rx_word[CTL_BITS-1:0];
    assign ev_addr  = ev_ctl[CTL_ADDR_MSB:CTL_ADDR_LSB];
    assign ev_rw    = ev_ctl[CTL_RW_BIT];
    assign ev_data  = ev_ctl[CTL_DATA_MSB:0];

    always_comb begin
        m_d           = m_q;
        m_d.dac_valid = 1'b0;
        wr_en         = 1'b0;
        wr_addr       = 3'h0;
        if (adc_valid) begin
            m_d.adc_hold = adc_sample;
        end
        // Supply must stay valid for the whole wait before the port runs
        if (!m_q.port_en) begin
            if (m_q.por_cnt == 32'(POR_WAIT - 1)) begin
                m_d.port_en = 1'b1;
            end else begin
                m_d.por_cnt = m_q.por_cnt + 32'h1;
            end
        end
        // Short dips restart the count and never gate
        if (low_m) begin
            if (m_q.low_cnt != 32'(LOWBAT)) begin
                m_d.low_cnt = m_q.low_cnt + 32'h1;
            end
        end else begin
            m_d.low_cnt = 32'h0;
        end
        m_d.dac_gate = !m_d.port_en || (m_d.low_cnt == 32'(LOWBAT));
        if (ev) begin
            m_d.rx_seen   = rx_tog_m;
            m_d.dac_valid = 1'b1;
            // 16-bit mode drops the four low bits of the word
            m_d.dac = dac_word_mode ?
                      {l_q.rx_word[RXW_BITS-2 -: 16], 4'h0} :
                      l_q.rx_word[RXW_BITS-2:RXW_AUDIO_LSB];
            if (ev_proto == PROTO_DSP) begin
                m_d.pend_valid = 1'b0;
                if (ev_addr != 3'h0) begin
                    if (ev_rw) begin
                        wr_en   = 1'b1;
                        wr_addr = ev_addr;
                    end else begin
                        m_d.rb_addr = ev_addr;
                    end
                end
            end else if (m_q.pend_valid) begin
                // Data phase uses the address of the earlier frame
                m_d.pend_valid = 1'b0;
                if (m_q.pend_rw) begin
                    wr_en   = 1'b1;
                    wr_addr = m_q.pend_addr;
                end
            end else if (ev_addr != 3'h0) begin
                m_d.pend_valid = 1'b1;
                m_d.pend_rw    = ev_rw;
                m_d.pend_addr  = ev_addr;
                if (!ev_rw) begin
                    m_d.rb_addr = ev_addr;
                end
            end
            // Writes to reserved addresses are dropped
            if (wr_en && (wr_addr >= REG_FIRST) && (wr_addr <= REG_LAST)) begin
                m_d.regs[wr_addr - 3'h1] = ev_data & REG_USED_MASK[wr_addr - 3'h1];
            end
            // Reply for a later frame: audio then readback byte
            m_d.tx_hold = {m_d.adc_hold, sacp_read(m_d.regs, m_d.rb_addr)};
            m_d.tx_tog  = ~m_q.tx_tog;
        end
        // Gating zeroes the word at once, not only at the next frame
        if (m_d.dac_gate) begin
            m_d.dac = '0;
        end
        // Unsynchronised power-on reset never reaches this logic
        if (rst || !por_ok_m) begin
            m_d      = '0;
            m_d.regs = REG_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        m_q <= m_d;
    end

    // ************************************************************
    // Outputs, all straight from flip-flops
    // ************************************************************
    assign sclk            = l_q.sclk;
    assign frame_sync      = l_q.frame;
    assign serial_out_line = l_q.sdo;
    assign dac_sample      = m_q.dac;
    assign dac_valid       = m_q.dac_valid;
    assign ctrl_regs       = m_q.regs;
    assign port_active     = m_q.port_en;
    assign dac_gated       = m_q.dac_gate;

    // ************************************************************
    // Checks
    // ************************************************************
    a_dsp_frame_half: assert property (@(posedge link_clk) disable iff (link_rst)
        (fall && (l_q.st == LS_FRAME) && (l_q.proto == PROTO_DSP) && (l_q.bit_idx == 5'd15))
        |=> !l_q.frame && (l_q.bit_idx == 5'd16))
        else $error("dsp frame strobe not low at half frame");

    a_spi_frame_low: assert property (@(posedge link_clk) disable iff (link_rst)
        ((l_q.st == LS_FRAME) && (l_q.proto == PROTO_SPI)) |-> !l_q.frame)
        else $error("spi frame strobe high during transaction");

    a_spi_idle_pulse: assert property (@(posedge link_clk) disable iff (link_rst)
        ((l_q.st == LS_IDLE) && (l_q.idle_cnt < 4'd4)) |-> l_q.frame)
        else $error("spi reset pulse missing in idle cycles");

    a_spi_idle_end: assert property (@(posedge link_clk) disable iff (link_rst)
        (fall && (l_q.st == LS_IDLE) && (l_q.idle_cnt == 4'd7))
        |=> ((l_q.st == LS_FRAME) && (l_q.bit_idx == 5'd0)) ##1 (l_q.st == LS_FRAME))
        else $error("spi idle period not eight clocks");

    a_rx_sample_rise: assert property (@(posedge link_clk) disable iff (link_rst)
        (rise && (l_q.st == LS_FRAME)) |=> (l_q.rx_sh[0] == $past(sin_l)) && l_q.sclk)
        else $error("input bit not taken on rising edge");

    a_tx_launch_fall: assert property (@(posedge link_clk) disable iff (link_rst)
        $changed(l_q.sdo) |-> $past(fall))
        else $error("output bit changed away from falling edge");

    a_zero_addr_idle: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        (ev && (ev_proto == PROTO_DSP) && (ev_addr == 3'h0)) |=> $stable(m_q.regs))
        else $error("register changed on zero address");

    a_dsp_write: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        (ev && (ev_proto == PROTO_DSP) && ev_rw && (ev_addr == 3'h1))
        |=> (m_q.regs[0] == $past(ev_data)) ##1 (m_q.regs[0] == $past(ev_data, 2)))
        else $error("dsp write did not land in register one");

    a_spi_two_frames: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        (ev && (ev_proto == PROTO_SPI) && !m_q.pend_valid && (ev_addr != 3'h0))
        |=> m_q.pend_valid && $stable(m_q.regs))
        else $error("spi access did not wait for second frame");

    a_unused_zero: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        ((m_q.regs & ~REG_USED_MASK) == '0))
        else $error("unused register bit set");

    a_por_wait: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        $rose(m_q.port_en) |-> ($past(m_q.por_cnt) == 32'(POR_WAIT - 1)))
        else $error("port enabled before supply wait ended");

    a_lowbat_gate: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        ($rose(m_q.dac_gate) && m_q.port_en) |-> (m_q.low_cnt == 32'(LOWBAT)))
        else $error("dac gated before low supply time");

    a_dac_short_word: assert property (@(posedge mclk) disable iff (rst || !por_ok_m)
        (dac_valid && $past(dac_word_mode)) |-> (dac_sample[3:0] == 4'h0))
        else $error("16-bit mode passed low bits");

endmodule : sacp_port

// *** sacp_partner.sv ***
`timescale 1ns/10ps
// ****************************************
// Far-end slave serial port
// ****************************************
module sacp_partner (
    input  wire logic sclk,
    input  wire logic frame_sync,
    input  wire logic serial_out_line,
    input  wire logic protocol_select_pin,
    output logic      serial_in_line
);
    logic [31:0] tx_q[$];
    logic [31:0] sh = 0;
    logic [23:0] rsh, rx_word;
    int          n = 40;
    logic        fs_old = 0;
    initial serial_in_line = 0;
    // Launch just after the fall; a rising strobe starts the frame.
    // The strobe edge covers the first frame, which has no falling clock.
    always @(negedge sclk or posedge frame_sync) begin
        #1;
        // SPI words follow the eight idle clocks back to back
        if (frame_sync && !fs_old)
            n = protocol_select_pin ? -8 : 0;
        else
            n = (protocol_select_pin && n == 31) ? 0 : n + 1;
        if (n == 0)
            sh = (tx_q.size() > 0) ? tx_q.pop_front() : 32'h0000_0000;
        fs_old = frame_sync;
        // Past the word the line toggles so no stale bit looks valid
        serial_in_line = (n >= 0 && n < 32) ? sh[31-n] : ~serial_in_line;
    end
    // Sample on the rise; first 24 bits are the reply
    always @(posedge sclk) begin
        rsh = {rsh[22:0], serial_out_line};
        if (n == 23) rx_word = rsh;
    end
endmodule : sacp_partner

// *** test_serial_audio_control_port.sv ***
`timescale 1ns/10ps
module test_serial_audio_control_port;
    import sacp_pkg::*;
    localparam int PW = 20;
    localparam int LB = 8;
    logic mclk = 0, rst = 1, link_clk = 0, por_rst_n = 0, supply_low = 0;
    logic protocol_select_pin = 0, dac_word_mode = 0, adc_valid = 0;
    logic [TX_AUDIO_BITS-1:0] adc_sample = 0;
    logic sclk, frame_sync, serial_out_line, serial_in_line, dac_valid;
    logic port_active, dac_gated;
    logic [RX_AUDIO_BITS-1:0] dac_sample;
    logic [NUM_REGS-1:0][7:0] ctrl_regs, regs;
    logic [31:0] w, exp_q[$];
    logic [15:0] a_q[$];
    logic [2:0] a;
    int n_errors = 0, n_compared = 0, k;
    realtime t;
    // Unrelated clock rates keep the crossing honest
    always #2 mclk = ~mclk;
    always #7.5 link_clk = ~link_clk;
    sacp_port #(.POR_WAIT(PW), .LOWBAT(LB)) sacp_port_i (
        .mclk                (mclk),
        .rst                 (rst),
        .link_clk            (link_clk),
        .por_rst_n           (por_rst_n),
        .supply_low          (supply_low),
        .protocol_select_pin (protocol_select_pin),
        .serial_in_line      (serial_in_line),
        .dac_word_mode       (dac_word_mode),
        .adc_sample          (adc_sample),
        .adc_valid           (adc_valid),
        .sclk                (sclk),
        .frame_sync          (frame_sync),
        .serial_out_line     (serial_out_line),
        .dac_sample          (dac_sample),
        .dac_valid           (dac_valid),
        .ctrl_regs           (ctrl_regs),
        .port_active         (port_active),
        .dac_gated           (dac_gated)
    );
    sacp_partner sacp_partner_i (
        .sclk                (sclk),
        .frame_sync          (frame_sync),
        .serial_out_line     (serial_out_line),
        .protocol_select_pin (protocol_select_pin),
        .serial_in_line      (serial_in_line)
    );
    task automatic chk(string what, logic [63:0] e, logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Wait for the next frame word at the mclk side
    task automatic next_frame;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (dac_valid !== 1'b1 && k < 9000);
        chk("dac_valid", 1, dac_valid);
    endtask : next_frame
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // Watchdog sized from fourteen frames, the idle gap and the strobe watch
    initial begin
        #420_000;
        n_errors++;
        conclude();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'ha1b4));
        regs = REG_RESET;
        repeat (5) @(negedge mclk);
        por_rst_n = 1;
        repeat (5) @(negedge mclk);
        rst = 0;
        chk("reset_regs", REG_RESET, ctrl_regs);
        repeat (PW - 2) @(negedge mclk);
        chk("early_active", 0, port_active);
        chk("early_gate", 1, dac_gated);
        repeat (4) @(negedge mclk);
        chk("active", 1, port_active);
        // Writes 1..5, a read of reserved 6, address 0, then reads of 3
        for (int i = 0; i < 10; i++) begin
            a = (i < 5) ? 3'(i + 1) : (i == 5) ? 3'h6 : (i == 6) ? 3'h0 : 3'h3;
            w = {20'($urandom), (i < 5) || (i == 6), a, 8'($urandom)};
            sacp_partner_i.tx_q.push_back(w);
            exp_q.push_back(w);
        end
        // Shift clock period from the divider constants
        @(posedge sclk) t = $realtime;
        @(posedge sclk) chk("sclk_period", 2 * SCLK_HALF_CYC * LINK_CLK_PS / 1000, int'($realtime - t));
        for (int e = 0; e < 10; e++) begin
            next_frame();
            w = exp_q.pop_front();
            if (w[10:8] >= 1 && w[10:8] <= 5 && w[11]) regs[w[10:8]-1] = w[7:0];
            chk("dac_sample", dac_word_mode ? {w[31:16], 4'h0} : w[31:12], dac_sample);
            chk("ctrl_regs", regs, ctrl_regs);
            // A reply is built after a frame and sent in the frame after next
            if (e >= 3) chk("adc_out", a_q[e-3], sacp_partner_i.rx_word[23:8]);
            if (e == 7) chk("readback_rsvd", 0, sacp_partner_i.rx_word[7:0]);
            if (e == 9) chk("readback", regs[2], sacp_partner_i.rx_word[7:0]);
            dac_word_mode = (e >= 5);
            adc_sample = 16'($urandom);
            a_q.push_back(adc_sample);
            adc_valid = 1;
            @(negedge mclk) adc_valid = 0;
        end
        // A dip shorter than the limit must not gate
        supply_low = 1;
        repeat (LB - 2) @(negedge mclk);
        supply_low = 0;
        repeat (6) @(negedge mclk);
        chk("gate_short", 0, dac_gated);
        supply_low = 1;
        repeat (LB + 6) @(negedge mclk);
        chk("gate_long", 1, dac_gated);
        chk("gated_dac", 0, dac_sample);
        supply_low = 0;
        // SPI: address frame, data frame, then audio only with rw set
        protocol_select_pin = 1;
        for (int i = 0; i < 3; i++) begin
            w = {20'($urandom), 1'b1, (i == 0) ? 3'h4 : 3'h0, 8'($urandom)};
            sacp_partner_i.tx_q.push_back(w);
            exp_q.push_back(w);
        end
        next_frame();
        for (int e = 0; e < 3; e++) begin
            next_frame();
            w = exp_q.pop_front();
            if (e == 1) regs[3] = w[7:0];
            chk("spi_dac", dac_word_mode ? {w[31:16], 4'h0} : w[31:12], dac_sample);
            chk("spi_regs", regs, ctrl_regs);
        end
        // SPI framing keeps the strobe low once frames run
        k = 0;
        repeat (7000) @(negedge mclk) k += (frame_sync !== 1'b0);
        chk("spi_frame_low", 0, k);
        conclude();
    end
endmodule : test_serial_audio_control_port
